/* File: hw/sar_pkg.sv */
package sar_pkg;
    // ****************************************
    // Sizes and codes
    // ****************************************
    localparam int DATA_W = 12;
    localparam int COUNT_W = 4;
    localparam logic [DATA_W-1:0] SAR_CLEAR = 12'h000;
    localparam logic [DATA_W-1:0] MSB_TRIAL = 12'h800;
    localparam int SYNC_W = 5;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int INT_HALF_NS = 800;
    localparam int INT_HALF_CYC = (INT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_NS = 25000;
    localparam int POWERUP_CYC = POWERUP_NS / CLK_PERIOD_NS;
    localparam int HALF_W = 8;
    localparam int TIMER_W = 12;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        SAR_ST_POWERUP = 2'b00,
        SAR_ST_IDLE = 2'b01,
        SAR_ST_CONVERT = 2'b10
    } sar_state_t;
endpackage : sar_pkg

/* File: hw/sar_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : sar_sync
`default_nettype wire

/* File: hw/sar_conversion_control.sv */
// Summary of operation
// - Long convert pulses accepted without accuracy loss.
// - Status time grows with convert pulse length.
// - Result reflects input when status falls.
// - Powerup timeout, then ready for convert.
// - Bit n fixed on pulse n+1 rise.
// - Thirteen pulses; status falls after thirteenth.
// - Convert during conversion is ignored.
// - Parallel outputs are active low.
// - Extra inverted MSB output for two's complement.
// - Serial bits only during conversion, MSB first.
// - Serial bits change with clock output.
// - Serial straight or offset code only.
// - Output clock pulses have equal widths on the internal clock; external clock widths pass through.
// - Lowest input gives all ones code.
// - Top of range gives all zeros code.
// - Conversion starts on convert rise; clock gated.
// - Short cycle ends conversion early.
`timescale 1ns/1ns
`default_nettype none
module sar_conversion_control
    import sar_pkg::*;
#(
    parameter int N_BITS = DATA_W,
    parameter int HALF_CYC = INT_HALF_CYC,
    parameter int PUP_CYC = POWERUP_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Host control
    input wire logic convert_in,
    input wire logic ext_clock_in,
    input wire logic clock_inhibit_in,
    input wire logic short_cycle_in,
    // Comparator
    input wire logic comparator_in,
    // Results
    output logic [N_BITS-1:0] data_b_out,
    output logic msb_inv_out,
    output logic serial_b_out,
    output logic bit_clock_out,
    output logic status_out
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [SYNC_W-1:0] synced;
    logic conv_s;
    logic ext_s;
    logic inhibit_s;
    logic short_s;
    logic comp_s;

    sar_sync #(.WIDTH(SYNC_W)) u_sync (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .async_in({convert_in, ext_clock_in, clock_inhibit_in, short_cycle_in, comparator_in}),
        .sync_out(synced)
    );

    assign {conv_s, ext_s, inhibit_s, short_s, comp_s} = synced;

    // ****************************************
    // State and edges
    // ****************************************
    sar_state_t state;
    logic conv_prev;
    logic ext_prev;
    logic [TIMER_W-1:0] timer;
    logic [HALF_W-1:0] half_cnt;
    logic pclk;
    logic next_pclk;
    logic pulse_edge;
    logic [COUNT_W-1:0] pulse_count;
    logic [COUNT_W-1:0] bit_idx;
    logic [N_BITS-1:0] sar;
    logic serial_bit;
    logic conv_rise;
    logic running;
    logic int_mode;
    logic decide;
    logic last;
    logic tail;
    logic clk_run;

    assign conv_rise = conv_s && !conv_prev;
    assign int_mode = inhibit_s;
    // Convert holds the clock only before the first pulse
    assign running = (state == SAR_ST_CONVERT) && (!conv_s || pulse_count != '0);
    // Last pulse finishes its high half after status falls
    assign clk_run = running || tail;
    assign bit_idx = COUNT_W'(N_BITS) - pulse_count;
    assign decide = pulse_edge && (pulse_count != '0);
    assign last = (pulse_count == COUNT_W'(N_BITS)) || short_s;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            conv_prev <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            conv_prev <= conv_s;
            ext_prev <= ext_s;
        end
    end

    // ****************************************
    // Conversion clock
    // ****************************************
    always_comb begin
        next_pclk = 1'b0;
        pulse_edge = 1'b0;
        if (clk_run && int_mode) begin
            next_pclk = pclk;
            if (half_cnt == HALF_W'(HALF_CYC - 1)) begin
                next_pclk = !pclk;
                pulse_edge = !pclk;
            end
        end else if (clk_run) begin
            pulse_edge = ext_s && !ext_prev;
            next_pclk = pulse_edge || (pclk && ext_s);
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tail <= 1'b0;
        end else if (state == SAR_ST_CONVERT && decide && last) begin
            tail <= 1'b1;
        end else if (!next_pclk) begin
            tail <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            half_cnt <= '0;
            pclk <= 1'b0;
        end else begin
            pclk <= next_pclk;
            if (!clk_run || !int_mode || half_cnt == HALF_W'(HALF_CYC - 1)) begin
                half_cnt <= '0;
            end else begin
                half_cnt <= half_cnt + 1'b1;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= SAR_ST_POWERUP;
            timer <= '0;
            pulse_count <= '0;
        end else begin
            case (state)
                SAR_ST_POWERUP: begin
                    timer <= timer + 1'b1;
                    if (timer == TIMER_W'(PUP_CYC - 1)) begin
                        state <= SAR_ST_IDLE;
                    end
                end
                SAR_ST_IDLE: begin
                    pulse_count <= '0;
                    if (conv_rise) begin
                        state <= SAR_ST_CONVERT;
                    end
                end
                SAR_ST_CONVERT: begin
                    // Further convert edges change nothing here
                    if (pulse_edge) begin
                        pulse_count <= pulse_count + 1'b1;
                        if (decide && last) begin
                            state <= SAR_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= SAR_ST_POWERUP;
                end
            endcase
        end
    end

    // ****************************************
    // Approximation register
    // ****************************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sar <= SAR_CLEAR;
            serial_bit <= 1'b0;
        end else if (state == SAR_ST_IDLE && conv_rise) begin
            sar <= SAR_CLEAR;
            serial_bit <= 1'b0;
        end else if (state == SAR_ST_CONVERT && pulse_edge) begin
            if (!decide) begin
                sar <= MSB_TRIAL;
            end else begin
                sar[bit_idx] <= comp_s;
                serial_bit <= comp_s;
                if (bit_idx != '0 && !short_s) begin
                    sar[bit_idx - 1'b1] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_b_out <= '1;
            msb_inv_out <= 1'b0;
            serial_b_out <= 1'b1;
            bit_clock_out <= 1'b0;
            status_out <= 1'b0;
        end else begin
            data_b_out <= ~sar;
            msb_inv_out <= sar[N_BITS-1];
            serial_b_out <= (state == SAR_ST_CONVERT || tail) ? ~serial_bit : 1'b1;
            bit_clock_out <= pclk;
            status_out <= (state == SAR_ST_CONVERT);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    start_on_rise_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state == SAR_ST_IDLE && conv_rise) |=> ##1 status_out)
        else $error("status did not rise after convert");

    ignore_convert_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state == SAR_ST_CONVERT && conv_rise && !pulse_edge)
        |=> (pulse_count == $past(pulse_count) && state == SAR_ST_CONVERT))
        else $error("convert during conversion not ignored");

    active_low_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state == SAR_ST_CONVERT && decide && last) |=> ##1 (data_b_out == ~sar))
        else $error("parallel result not complemented");

    inv_msb_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        msb_inv_out == ~data_b_out[N_BITS-1])
        else $error("inverted msb mismatch");

    serial_idle_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state != SAR_ST_CONVERT && !tail) [*2] |-> serial_b_out)
        else $error("serial output active outside conversion");

    powerup_wait_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state == SAR_ST_POWERUP) |-> (timer < TIMER_W'(PUP_CYC)))
        else $error("powerup timeout overran");

    end_after_last_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state == SAR_ST_CONVERT && decide && last) |=> ##1 !status_out)
        else $error("status did not fall after last pulse");

    equal_width_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (clk_run && int_mode && $past(clk_run) && $changed(pclk))
        |-> ($past(half_cnt) == HALF_W'(HALF_CYC - 1)))
        else $error("clock pulse width unequal");

    bit_fixed_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state == SAR_ST_CONVERT && decide) |=> (sar[$past(bit_idx)] == $past(comp_s)))
        else $error("bit decision not taken from comparator");

    clock_gated_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state != SAR_ST_CONVERT && !tail) [*2] |-> ##1 !bit_clock_out)
        else $error("clock output ran outside conversion");
endmodule : sar_conversion_control
`default_nettype wire

/* File: testbench/sar_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_host_model
    import sar_pkg::*;
(
    // Control
    input wire logic ext_run_in,
    input wire logic [DATA_W-1:0] level_in,
    input wire logic [DATA_W-1:0] data_b_in,
    // Drives
    output logic comparator_out,
    output logic ext_clock_out
);
    // ****************************************
    // Comparator and external clock
    // ****************************************
    // Input level held steady; trial kept when not above it
    assign comparator_out = ((~data_b_in) <= level_in);
    // Clock toggles only within frames, idles low
    initial begin
        ext_clock_out = 1'b0;
        #7;
        forever begin
            #160;
            ext_clock_out = ext_run_in ? ~ext_clock_out : 1'b0;
        end
    end
endmodule : sar_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import sar_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int HC = 2;
    localparam int PC = 10;
    logic clock_in, rst_b_in, convert_in, clock_inhibit_in, short_cycle_in, ext_run;
    logic comparator, ext_clock, msb_inv_out, serial_b_out, bit_clock_out, status_out;
    logic [DATA_W-1:0] level, data_b_out;
    int errors, compares;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

    sar_conversion_control #(.HALF_CYC(HC), .PUP_CYC(PC)) i_dut (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .convert_in(convert_in),
        .ext_clock_in(ext_clock), .clock_inhibit_in(clock_inhibit_in),
        .short_cycle_in(short_cycle_in), .comparator_in(comparator),
        .data_b_out(data_b_out), .msb_inv_out(msb_inv_out), .serial_b_out(serial_b_out),
        .bit_clock_out(bit_clock_out), .status_out(status_out));
    sar_host_model i_host (.ext_run_in(ext_run), .level_in(level), .data_b_in(data_b_out),
        .comparator_out(comparator), .ext_clock_out(ext_clock));

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task step;
        @(posedge clock_in);
        #1;
    endtask : step

    task final_report;
        $display("Counts: errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task run_conv(input logic [11:0] lv, input int hold, input logic ext, input logic shrt,
                  input logic retrig, input int npulse, input logic [11:0] exp_d);
        int c, pulses, hw, w0, early;
        logic prev, grab, seen;
        logic [11:0] ser;
        level = lv;
        clock_inhibit_in = ~ext;
        short_cycle_in = shrt;
        ext_run = ext;
        {c, pulses, hw, w0, early, prev, grab, seen, ser} = '0;
        while (c < 600 && !(seen && status_out === 1'b0 && !prev)) begin
            convert_in = (c < hold) || (retrig && c >= 30 && c < 33);
            step;
            c++;
            if (status_out === 1'b1) seen = 1'b1;
            if (grab) ser = {ser[10:0], serial_b_out};
            grab = 1'b0;
            if (bit_clock_out === 1'b1 && !prev) begin
                pulses++;
                grab = (pulses > 1);
                if (c < hold) early++;
            end
            if (bit_clock_out === 1'b1) hw++;
            if (bit_clock_out === 1'b0 && prev) begin
                if (w0 == 0) w0 = hw;
                `CHK(hw, w0)
                hw = 0;
            end
            prev = bit_clock_out;
        end
        ext_run = 1'b0;
        convert_in = 1'b0;
        `CHK(c < 600, 1'b1)
        `CHK(pulses, npulse)
        `CHK(early, 0)
        `CHK(data_b_out, exp_d)
        `CHK(msb_inv_out, ~exp_d[11])
        if (npulse == 13) `CHK(ser, exp_d)
        `CHK(serial_b_out, 1'b1)
        `CHK(bit_clock_out, 1'b0)
        repeat (3) step;
    endtask : run_conv

    task test_powerup;
        int i;
        rst_b_in = 1'b1;
        for (i = 0; i < 8; i++) begin
            convert_in = (i < 3);
            step;
            `CHK(status_out, 1'b0)
        end
        repeat (PC + 10) step;
        run_conv(12'ha5c, 3, 1'b0, 1'b0, 1'b0, 13, ~12'ha5c);
        $display("test powerup done");
    endtask : test_powerup

    task test_codes;
        run_conv(12'h000, 3, 1'b0, 1'b0, 1'b0, 13, 12'hfff);
        run_conv(12'hfff, 3, 1'b0, 1'b0, 1'b0, 13, 12'h000);
        run_conv(12'h801, 3, 1'b0, 1'b0, 1'b0, 13, 12'h7fe);
        $display("test codes done");
    endtask : test_codes

    task test_modes;
        run_conv(12'h3c6, 3, 1'b0, 1'b0, 1'b1, 13, ~12'h3c6);
        run_conv(12'h5a3, 60, 1'b0, 1'b0, 1'b0, 13, ~12'h5a3);
        run_conv(12'hc35, 3, 1'b1, 1'b0, 1'b1, 13, ~12'hc35);
        run_conv(12'h9ff, 3, 1'b0, 1'b1, 1'b0, 2, 12'h7ff);
        $display("test modes done");
    endtask : test_modes

    initial begin
        {rst_b_in, convert_in, short_cycle_in, ext_run, errors, compares} = '0;
        clock_inhibit_in = 1'b1;
        level = '0;
        repeat (16) step;
        `CHK(data_b_out, 12'hfff)
        `CHK({status_out, serial_b_out, bit_clock_out, msb_inv_out}, 4'h4)
        $display("test reset done");
        test_powerup;
        test_codes;
        test_modes;
        final_report;
    end

    initial begin
        #200000;
        errors++;
        $display("[FAIL] t=%0t watchdog", $time);
        final_report;
    end
endmodule : tb_top
`default_nettype wire
